// [core/cdc_pkg.sv]
// Purpose: Shared constants and types for the cached DRAM bus controller.
// Assumes: 40 MHz clock, four banks of cached DRAM modules.
// Notes: Address decode limits and sequence states live here.
package cdc_pkg;
    localparam int ROW_W = 11;
    localparam int BANK_W = 2;
    localparam int LRR_W = ROW_W + BANK_W;
    localparam int NBANK = 4;
    localparam int MUX_W = 10;
    localparam int BURST_BITS = 2;
    localparam int COL_HI = 8;
    localparam int INIT_REF = 8;
    // Address field positions within a byte address (bits 2 and up used).
    localparam int COL_LSB = 2;
    localparam int ROW_LSB = 11;
    localparam int BANK_LSB = 22;
    localparam int TOP_BIT = 31;
    // Hole between 640K and 1M, expressed as address bits 19:16.
    localparam logic [3:0] HOLE_LO = 4'hA;
    localparam logic [7:0] MEM_TOP = 8'h00;
    localparam int REFRESH_PERIOD_NS = 15000;
    typedef enum logic [3:0] {
        CDC_IDLE, CDC_RD_S1, CDC_RD_S2, CDC_RD_S3, CDC_RD_S4, CDC_RD_S5,
        CDC_WR_S1, CDC_WR_S2, CDC_REF_S1, CDC_REF_S2, CDC_RST_REF
    } cdc_state_t;
endpackage

// [core/cdc_last_row.sv]
// Purpose: Last-read row register and hit/miss comparator.
// Assumes: Loaded by the sequencer only on a read miss.
// Notes: Starts invalid so the first read after reset is a miss.
`timescale 1ns/100ps
module cdc_last_row
    import cdc_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic load,
    input wire logic [LRR_W-1:0] new_tag,
    output logic hit
);
    logic [LRR_W-1:0] last_read_row_reg;
    logic valid;

    // Holds the row and bank of the last miss; cleared by reset.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            last_read_row_reg <= '0;
            valid <= 1'b0;
        end else if (ce && load) begin
            last_read_row_reg <= new_tag;
            valid <= 1'b1;
        end
    end

    // Compare is combinational so the sequencer picks the branch at once.
    assign hit = valid && (last_read_row_reg == new_tag);
endmodule

// [core/cdc_ctrl.sv]
// Purpose: Sequencer for a cached DRAM array behind a burst processor bus.
// Assumes: All inputs synchronous to clk; reset input rst is high active.
// Notes: One burst read, single write and refresh sequences.
//
// How it works
// - Separate row-enable and chip-select for each of four banks.
// - Refresh tick rising edge raises a refresh request.
// - Thirteen bit register keeps row and bank of last read.
// - Each read compares row and bank against it to pick hit or miss.
// - Row, column or burst address on two bank-pair buses, top bit per bank.
// - Burst steps two low bits in interleaved order; bits 2-8 stay column.
// - Respond only to memory below 16 Mbyte, excluding 640K to 1M.
// - During reset initialise, enable refresh, ignore bus requests.
// - During reset issue eight refresh cycles.
// - After reset release go idle and wait.
// - Start on strobe, hold acknowledge with valid address, or refresh.
// - Sequence chosen from write/read, ISA strobes and hit result.
// - Read hit: column, output enable, select, burst ack in rd_s2.
// - Claim local device and block chipset strobe during own cycles.
// - Burst continues rd_s3 to rd_s5 until burst_last_n low.
// - Read miss rd_s1: row address, read mode, select and row enable together.
// - Read miss rd_s2: column address, output enable, burst ack.
// - Write is one row-enable cycle; only enabled byte latches fire.
// - wr_s1: row address, write mode, select, row enable, single ack.
// - wr_s2: column, write enable, byte latches; all drop at end.
// - Refresh pending in idle goes to ref_s1 with refresh select.
// - Next event caught in ref_s2; hit to rd_s2, else idle wait.
// - Heavy controls split low/high; byte latches shared by all banks.
`timescale 1ns/100ps
module cdc_ctrl
    import cdc_pkg::*;
#(
    parameter int CLK_PERIOD_NS = 25
)(
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic rst,
    input wire logic [31:2] addr,
    input wire logic mem_io,
    input wire logic write_read,
    input wire logic [3:0] byte_en_n,
    input wire logic addr_strobe_n,
    input wire logic burst_last_n,
    input wire logic hold_ack,
    input wire logic isa_mem_rd_n,
    input wire logic isa_mem_wr_n,
    input wire logic refresh_tick,
    input wire logic chipset_strobe_in_n,
    input wire logic chipset_cacheable_n,
    output logic chipset_strobe_n,
    output logic cacheable_n,
    output logic local_dev_claim_n,
    output logic burst_ack_n,
    output logic single_ack_n,
    output logic [MUX_W-1:0] mux_addr_low,
    output logic [MUX_W-1:0] mux_addr_high,
    output logic [NBANK-1:0] addr_top,
    output logic [NBANK-1:0] row_en_n,
    output logic [NBANK-1:0] chip_sel_n,
    output logic [3:0] col_latch_n,
    output logic [1:0] mem_write_read,
    output logic [1:0] refresh_sel_n,
    output logic [1:0] out_en_n,
    output logic [1:0] wr_en_n
);
    ////////////////////////////////////////////////////////////////////////
    cdc_state_t state;
    cdc_state_t next_state;
    logic tick_d;
    logic ref_pend;
    logic [3:0] init_cnt;
    logic hit;
    logic addr_ok;
    logic start;
    logic is_write;
    logic lrr_load;
    logic [1:0] burst_ofs;
    logic [LRR_W-1:0] tag;
    logic [BANK_W-1:0] bank;
    logic [BANK_W-1:0] cur_bank;
    logic [ROW_W-1:0] row_a;
    logic [ROW_W-1:0] col_a;
    logic [3:0] be_lat;
    logic [ROW_W-1:0] next_ma;
    logic [1:0] ma_sel;

    // The tick period is kept for reference; refresh is paced by the tick.
    localparam int REF_CYC = REFRESH_PERIOD_NS / CLK_PERIOD_NS;

    // Decode: memory, whole top byte zero, not in 640K..1M.
    // The top byte check keeps the array from aliasing above 16 Mbyte.
    assign addr_ok = mem_io && addr[TOP_BIT:BANK_LSB+BANK_W] == MEM_TOP
        && !(addr[19:16] >= HOLE_LO && addr[23:20] == 4'h0);
    assign bank = addr[BANK_LSB+1:BANK_LSB];
    assign row_a = addr[ROW_LSB+ROW_W-1:ROW_LSB];
    assign col_a = {2'b00, addr[ROW_LSB-1:COL_LSB]};
    assign tag = {bank, row_a};
    // ISA strobes override the processor write/read level when DMA owns it.
    assign is_write = hold_ack ? !isa_mem_wr_n : write_read;
    assign start = addr_ok && (!addr_strobe_n || (hold_ack &&
        (!isa_mem_rd_n || !isa_mem_wr_n)));
    assign lrr_load = (next_state == CDC_RD_S1) && (state != CDC_RD_S1);

    cdc_last_row u_lrr (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .load(lrr_load),
        .new_tag(tag),
        .hit(hit)
    );

    ////////////////////////////////////////////////////////////////////////
    // Refresh request: tick edge sets, starting ref_s1 clears; set wins.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tick_d <= 1'b0;
            ref_pend <= 1'b0;
        end else if (ce) begin
            tick_d <= refresh_tick;
            if (refresh_tick && !tick_d)
                ref_pend <= 1'b1;
            else if (next_state == CDC_REF_S1 && state != CDC_REF_S1)
                ref_pend <= 1'b0;
        end
    end

    // Eight refresh cycles are counted while reset is high.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            init_cnt <= '0;
        end else if (ce) begin
            if (!rst)
                init_cnt <= '0;
            else if (state == CDC_REF_S2 && init_cnt != 4'(INIT_REF))
                init_cnt <= init_cnt + 4'h1;
        end
    end

    // Next-state logic.
    always_comb begin
        next_state = state;
        unique case (state)
            CDC_IDLE: begin
                if (rst && init_cnt != 4'(INIT_REF))
                    next_state = CDC_REF_S1;
                else if (rst)
                    next_state = CDC_IDLE;
                else if (ref_pend)
                    next_state = CDC_REF_S1;
                else if (start && is_write)
                    next_state = CDC_WR_S1;
                else if (start && hit)
                    next_state = CDC_RD_S2;
                else if (start)
                    next_state = CDC_RD_S1;
            end
            CDC_RD_S1: next_state = CDC_RD_S2;
            CDC_RD_S2, CDC_RD_S3, CDC_RD_S4: next_state = burst_last_n ?
                cdc_state_t'(state + 4'h1) : CDC_IDLE;
            CDC_RD_S5: next_state = CDC_IDLE;
            CDC_WR_S1: next_state = CDC_WR_S2;
            CDC_WR_S2: next_state = CDC_IDLE;
            CDC_REF_S1: next_state = CDC_REF_S2;
            CDC_REF_S2: begin
                if (!rst && start && !is_write && hit)
                    next_state = CDC_RD_S2;
                else
                    next_state = CDC_IDLE;
            end
            default: next_state = CDC_IDLE;
        endcase
    end

    // State register; reset release leaves it in idle.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            state <= CDC_IDLE;
        else if (ce)
            state <= next_state;
    end

    // Bank and byte enables are captured when a sequence starts.
    // The burst counter holds the word index, not an address, so every
    // start offset follows the interleaved order.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cur_bank <= '0;
            be_lat <= 4'hF;
            burst_ofs <= '0;
        end else if (ce) begin
            if (state == CDC_IDLE || state == CDC_REF_S2) begin
                cur_bank <= bank;
                be_lat <= byte_en_n;
                burst_ofs <= '0;
            end else if (state == CDC_RD_S2 || state == CDC_RD_S3 ||
                state == CDC_RD_S4) begin
                burst_ofs <= burst_ofs + 2'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Address mux: row in rd_s1/wr_s1, column otherwise, burst low bits.
    always_comb begin
        ma_sel = 2'b00;
        if (next_state == CDC_RD_S1 || next_state == CDC_WR_S1)
            ma_sel = 2'b01;
        else if (next_state == CDC_RD_S3 || next_state == CDC_RD_S4 ||
            next_state == CDC_RD_S5)
            ma_sel = 2'b10;
        unique case (ma_sel)
            2'b01: next_ma = row_a;
            2'b10: next_ma = {col_a[ROW_W-1:BURST_BITS],
                col_a[BURST_BITS-1:0] ^ (burst_ofs + 2'h1)};
            default: next_ma = col_a;
        endcase
    end

    // Registered DRAM control outputs, derived from the next state.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mux_addr_low <= '0;
            mux_addr_high <= '0;
            addr_top <= '0;
            row_en_n <= '1;
            chip_sel_n <= '1;
            col_latch_n <= 4'hF;
            mem_write_read <= '0;
            refresh_sel_n <= 2'b11;
            out_en_n <= 2'b11;
            wr_en_n <= 2'b11;
            burst_ack_n <= 1'b1;
            single_ack_n <= 1'b1;
            local_dev_claim_n <= 1'b1;
        end else if (ce) begin
            mux_addr_low <= next_ma[MUX_W-1:0];
            mux_addr_high <= next_ma[MUX_W-1:0];
            addr_top <= {NBANK{next_ma[ROW_W-1]}};
            row_en_n <= '1;
            chip_sel_n <= '1;
            col_latch_n <= 4'hF;
            refresh_sel_n <= 2'b11;
            out_en_n <= 2'b11;
            wr_en_n <= 2'b11;
            burst_ack_n <= 1'b1;
            single_ack_n <= 1'b1;
            local_dev_claim_n <= (next_state == CDC_IDLE ||
                next_state == CDC_REF_S1 || next_state == CDC_REF_S2);
            mem_write_read <= {2{next_state == CDC_WR_S1 ||
                next_state == CDC_WR_S2}};
            unique case (next_state)
                CDC_RD_S1: begin
                    chip_sel_n[bank] <= 1'b0;
                    row_en_n[bank] <= 1'b0;
                end
                CDC_RD_S2, CDC_RD_S3, CDC_RD_S4, CDC_RD_S5: begin
                    chip_sel_n[state == CDC_IDLE || state == CDC_REF_S2 ?
                        bank : cur_bank] <= 1'b0;
                    out_en_n <= 2'b00;
                    burst_ack_n <= 1'b0;
                end
                CDC_WR_S1: begin
                    chip_sel_n[bank] <= 1'b0;
                    row_en_n[bank] <= 1'b0;
                    single_ack_n <= 1'b0;
                end
                CDC_WR_S2: begin
                    chip_sel_n[cur_bank] <= 1'b0;
                    row_en_n[cur_bank] <= 1'b0;
                    wr_en_n <= 2'b00;
                    col_latch_n <= be_lat;
                end
                CDC_REF_S1: refresh_sel_n <= 2'b00;
                CDC_REF_S2: row_en_n <= '0;
                default: ;
            endcase
        end
    end

    // Chipset strobe passes through except during our own cycles.
    assign chipset_strobe_n = chipset_strobe_in_n || !local_dev_claim_n
        || (start && !rst);
    assign cacheable_n = chipset_cacheable_n && !(addr_ok && !rst);

    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence s_tick_edge;
        ce && refresh_tick && !tick_d;
    endsequence
    sequence s_burst_go;
        ce && state == CDC_RD_S2 && burst_last_n;
    endsequence

    a_tick_sets_req: assert property (s_tick_edge |=> ref_pend)
        else $error("refresh tick not registered");
    a_idle_to_ref: assert property (ce && state == CDC_IDLE && ref_pend
        && !rst |=> state == CDC_REF_S1)
        else $error("pending refresh not started");
    a_ref_sel_low: assert property (state == CDC_REF_S1 |->
        refresh_sel_n == 2'b00)
        else $error("refresh select missing");
    a_burst_step: assert property (s_burst_go |=> state == CDC_RD_S3
        && !burst_ack_n && out_en_n == 2'b00)
        else $error("burst did not continue");
    a_write_ack: assert property (state == CDC_WR_S1 |->
        !single_ack_n && mem_write_read == 2'b11 && row_en_n != 4'hF)
        else $error("write phase one wrong");
    a_write_bytes: assert property (ce && state == CDC_WR_S1 |=>
        col_latch_n == $past(be_lat) && wr_en_n == 2'b00)
        else $error("byte latches wrong");
    a_write_end: assert property (ce && state == CDC_WR_S2 && !rst
        |=> col_latch_n == 4'hF && wr_en_n == 2'b11)
        else $error("write not terminated");
    a_claim_read: assert property (state == CDC_RD_S2 |->
        !local_dev_claim_n && chipset_strobe_n && !burst_ack_n)
        else $error("claim missing in read");
    a_reset_quiet: assert property (ce && rst && state == CDC_IDLE |=>
        state == CDC_IDLE || state == CDC_REF_S1)
        else $error("bus cycle during reset");
endmodule

// [sim/cdc_cpu_model.sv]
// Purpose: Processor-side model that ends each burst after a set count.
// Assumes: Words are counted from the acknowledges after each strobe.
// Notes: The bench picks the burst length through n_words.
`timescale 1ns/100ps
module cdc_cpu_model (
    input wire logic clk,
    input wire logic rstn,
    input wire logic addr_strobe_n,
    input wire logic burst_ack_n,
    input wire logic [2:0] n_words,
    output logic burst_last_n
);
    logic [2:0] seen;

    ////////////////////////////////////////////////////////////////////////
    // Words taken so far; a fresh strobe restarts the count.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            seen <= 3'h0;
        end else if (!addr_strobe_n) begin
            seen <= 3'h0;
        end else if (!burst_ack_n) begin
            seen <= seen + 3'h1;
        end
    end

    // Low from the final word until a fresh strobe, as a real processor would drive it.
    assign burst_last_n = (seen + 3'h1 < n_words);
endmodule

// [sim/tb_cached_dram_bus_controller.sv]
// Purpose: Self-checking bench for the cached DRAM bus controller.
// Assumes: Outputs are sampled 1 ns after the rising edge.
// Notes: The chipset strobe input is held low to watch its gating.
`timescale 1ns/100ps
module tb_cached_dram_bus_controller;
    import cdc_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic ce = 1'b1;
    logic rst = 1'b0;
    logic [31:2] addr = 30'h0;
    logic mem_io = 1'b1;
    logic write_read = 1'b0;
    logic [3:0] byte_en_n = 4'hF;
    logic addr_strobe_n = 1'b1;
    logic hold_ack = 1'b0;
    logic isa_mem_rd_n = 1'b1;
    logic isa_mem_wr_n = 1'b1;
    logic refresh_tick = 1'b0;
    logic chipset_strobe_in_n = 1'b0;
    logic chipset_cacheable_n = 1'b1;
    logic [2:0] n_words = 3'h1;
    logic burst_last_n, chipset_strobe_n, cacheable_n, local_dev_claim_n;
    logic burst_ack_n, single_ack_n;
    logic [MUX_W-1:0] mux_addr_low, mux_addr_high;
    logic [3:0] addr_top, row_en_n, chip_sel_n, col_latch_n;
    logic [1:0] mem_write_read, refresh_sel_n, out_en_n, wr_en_n;
    int err_total = 0;
    int num_checks = 0;

    ////////////////////////////////////////////////////////////////////////
    // Clock, design and processor model.
    always #12.5 clk = ~clk;

    cdc_ctrl #(.CLK_PERIOD_NS(25)) DUT (.clk, .rstn, .ce, .rst, .addr,
        .mem_io, .write_read, .byte_en_n, .addr_strobe_n, .burst_last_n,
        .hold_ack, .isa_mem_rd_n, .isa_mem_wr_n, .refresh_tick,
        .chipset_strobe_in_n, .chipset_cacheable_n, .chipset_strobe_n,
        .cacheable_n, .local_dev_claim_n, .burst_ack_n, .single_ack_n,
        .mux_addr_low, .mux_addr_high, .addr_top, .row_en_n, .chip_sel_n,
        .col_latch_n, .mem_write_read, .refresh_sel_n, .out_en_n, .wr_en_n);

    cdc_cpu_model cpu (.clk, .rstn, .addr_strobe_n, .burst_ack_n, .n_words,
        .burst_last_n);

    ////////////////////////////////////////////////////////////////////////
    // Shared helpers.
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic nxt();
        @(posedge clk);
        #1;
    endtask

    // A wait that used up its bound ends the run.
    task automatic bound(int n);
        if (n >= 8) begin
            err_total++;
            $display("ERROR wait bound expected 7 seen %0d", n);
            report_and_stop();
        end
    endtask

    function automatic logic [31:2] mk(logic [1:0] b, logic [10:0] r,
                                       logic [8:0] c);
        return {8'h00, b, r, c};
    endfunction

    // One strobe cycle; returns just after the edge that takes it.
    task automatic start(logic [31:2] a, logic wr, logic mio, logic [3:0] be);
        @(posedge clk);
        addr <= a;
        write_read <= wr;
        mem_io <= mio;
        byte_en_n <= be;
        addr_strobe_n <= 1'b0;
        @(posedge clk);
        addr_strobe_n <= 1'b1;
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Scenarios.
    // Chip reset: refreshes run while strobes are ignored.
    task automatic t_reset();
        int refs;
        int acks;
        logic prev;
        refs = 0;
        acks = 0;
        prev = 1'b1;
        addr <= mk(2'h1, 11'h123, 9'h000);
        rst <= 1'b1;
        addr_strobe_n <= 1'b0;
        repeat (100) begin
            nxt();
            if (prev === 1'b1 && refresh_sel_n[0] === 1'b0) refs++;
            if (burst_ack_n === 1'b0) acks++;
            prev = refresh_sel_n[0];
        end
        check("reset refreshes", refs, INIT_REF);
        check("reset acks", acks, 0);
        @(posedge clk);
        rst <= 1'b0;
        addr_strobe_n <= 1'b1;
        repeat (4) nxt();
    endtask

    // Read of nw words; a miss shows the row cycle before the first word.
    task automatic t_read(logic [1:0] b, logic [10:0] r, logic [8:0] c,
                          logic [2:0] nw, logic miss);
        logic [9:0] mx;
        logic [3:0] sel;
        int k;
        sel = ~(4'h1 << b);
        n_words <= nw;
        start(mk(b, r, c), 1'b0, 1'b1, 4'h0);
        mx = b[1] ? mux_addr_high : mux_addr_low;
        if (miss) begin
            check("miss select", chip_sel_n, sel);
            check("miss row enable", row_en_n[b], 1'b0);
            check("miss read mode", mem_write_read[b[1]], 1'b0);
            check("miss row address", {addr_top[b], mx}, r);
            check("miss early ack", burst_ack_n, 1'b1);
            nxt();
        end
        k = 0;
        while (burst_ack_n === 1'b0 && k < 6) begin
            mx = b[1] ? mux_addr_high : mux_addr_low;
            check("burst low bits", mx[1:0], c[1:0] ^ k[1:0]);
            check("burst column", mx[8:2], c[8:2]);
            check("read enable", out_en_n[b[1]], 1'b0);
            check("read select", chip_sel_n, sel);
            check("claim", {local_dev_claim_n, chipset_strobe_n}, 2'h1);
            k++;
            nxt();
        end
        check("burst words", k, nw);
        nxt();
    endtask

    // Partial write to bank 1: only two byte latches may fire.
    task automatic t_write();
        start(mk(2'h1, 11'h124, 9'h033), 1'b1, 1'b1, 4'hA);
        check("write ack", single_ack_n, 1'b0);
        check("write mode", mem_write_read[0], 1'b1);
        check("write row", {row_en_n, chip_sel_n}, 8'hDD);
        check("write row addr", mux_addr_low, 10'h124);
        @(posedge clk);
        ce <= 1'b0;
        #1;
        check("write latch", col_latch_n, 4'hA);
        check("write enable", wr_en_n[0], 1'b0);
        check("write column", mux_addr_low[8:0], 9'h033);
        // Clock enable low must freeze the write in its second phase.
        repeat (2) nxt();
        check("write frozen", {col_latch_n, wr_en_n}, 6'h28);
        @(posedge clk);
        ce <= 1'b1;
        nxt();
        check("write end", {col_latch_n, wr_en_n, row_en_n}, 10'h3FF);
        nxt();
    endtask

    // Decode edges: only the two addresses beside the hole are taken.
    task automatic t_decode();
        logic [31:2] tbl [6];
        logic ok;
        tbl = '{30'h20000000, 30'h00400000, 30'h00028000, 30'h0003FFFF,
                30'h00027FFF, 30'h00040000};
        for (int i = 0; i < 7; i++) begin
            ok = (i == 4 || i == 5);
            start(tbl[i == 6 ? 5 : i], 1'b1, i != 6, 4'h0);
            check("decode ack", single_ack_n, !ok);
            check("chipset gate", chipset_strobe_n, ok);
            check("cacheable", cacheable_n, !ok);
            repeat (3) nxt();
        end
    endtask

    // Tick edge, then a held read hit that is served from ref_s2.
    task automatic t_refresh();
        int n;
        @(posedge clk);
        n_words <= 3'h1;
        addr <= mk(2'h1, 11'h123, 9'h000);
        write_read <= 1'b0;
        mem_io <= 1'b1;
        refresh_tick <= 1'b1;
        @(posedge clk);
        addr_strobe_n <= 1'b0;
        n = 0;
        nxt();
        while (refresh_sel_n !== 2'h0 && n < 8) begin
            nxt();
            n++;
        end
        bound(n);
        check("refresh first", burst_ack_n, 1'b1);
        nxt();
        check("refresh rows", row_en_n, 4'h0);
        nxt();
        check("hit after refresh", burst_ack_n, 1'b0);
        @(posedge clk);
        addr_strobe_n <= 1'b1;
        n = 0;
        repeat (8) begin
            nxt();
            if (refresh_sel_n !== 2'h3) n++;
        end
        check("one refresh per tick", n, 0);
        refresh_tick <= 1'b0;
    endtask

    // Bus master cycles through hold acknowledge and the ISA strobes.
    task automatic t_isa();
        int n;
        @(posedge clk);
        addr <= mk(2'h1, 11'h123, 9'h004);
        byte_en_n <= 4'hC;
        hold_ack <= 1'b1;
        isa_mem_rd_n <= 1'b0;
        n = 0;
        nxt();
        while (out_en_n[0] !== 1'b0 && n < 8) begin
            nxt();
            n++;
        end
        bound(n);
        check("isa read claim", local_dev_claim_n, 1'b0);
        @(posedge clk);
        isa_mem_rd_n <= 1'b1;
        isa_mem_wr_n <= 1'b0;
        n = 0;
        nxt();
        while (wr_en_n[0] !== 1'b0 && n < 8) begin
            nxt();
            n++;
        end
        bound(n);
        check("isa write latch", col_latch_n, 4'hC);
        @(posedge clk);
        hold_ack <= 1'b0;
        isa_mem_wr_n <= 1'b1;
        repeat (4) nxt();
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence; the watchdog ends a hung run through the same report.
    initial begin
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_reset();
        t_read(2'h1, 11'h123, 9'h005, 3'h4, 1'b1);
        t_read(2'h1, 11'h123, 9'h01A, 3'h4, 1'b0);
        t_read(2'h2, 11'h123, 9'h1F3, 3'h1, 1'b1);
        t_read(2'h1, 11'h123, 9'h007, 3'h2, 1'b1);
        t_write();
        t_decode();
        t_refresh();
        t_isa();
        report_and_stop();
    end

    initial begin
        #2000000;
        err_total++;
        report_and_stop();
    end
endmodule
